/* pkg/rcs_defs.svh */
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH
// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define RCS_IDX_PWR 2'h0
`define RCS_IDX_VSEL 2'h1
`define RCS_IDX_CFG 2'h2
`define RCS_IDX_FLT 2'h3
`define RCS_RST_VAL 8'h00
`define RCS_PWR_MASK 8'hF8
`define RCS_VSEL_MASK 8'hFE
`define RCS_CFG_MASK 8'hFB
// ****************************************
// Field positions
// ****************************************
`define RCS_PWR_RAILS 7:4
`define RCS_PWR_LAMP 7
`define RCS_PWR_DISC 6
`define RCS_PWR_AUDIO 5
`define RCS_PWR_SYS 4
`define RCS_PWR_SW 3
`define RCS_CFG_IGN 7:6
`define RCS_CFG_LOW 5:4
`define RCS_CFG_MODE 3
// ****************************************
// Comparator levels, mV and degrees C
// ****************************************
`define RCS_LOW_8V0 16'h1F40
`define RCS_LOW_8V5 16'h2134
`define RCS_LOW_7V5 16'h1D4C
`define RCS_LOW_9V0 16'h2328
`define RCS_LOW_6V5 16'h1964
`define RCS_LOW_7V0 16'h1B58
`define RCS_IGN_4V2 16'h1068
`define RCS_IGN_3V6 16'h0E10
`define RCS_IGN_3V2 16'h0C80
`define RCS_IGN_2V7 16'h0A8C
`define RCS_HIGH_LVL 16'h4650
`define RCS_SURGE_LVL 16'h5208
`define RCS_SURGE_REL 16'h5014
`define RCS_CORE_LOW 16'h0AF0
`define RCS_CORE_REL 16'h0B2C
`define RCS_HOT_LVL 8'h8C
`define RCS_HOT_REL 8'h82
`define RCS_TSD_LVL 8'hAF
`define RCS_TSD_REL 8'h91
// ****************************************
// Timing
// ****************************************
`define RCS_CLK_MHZ 200
`define RCS_NS_PER_US 1000
`define RCS_ASSERT_DELAY_NS 10000
`define RCS_RELEASE_DELAY_NS 50000
`endif

/* pkg/rcs_pkg.sv */
package rcs_pkg;
   typedef struct packed {
      logic ign_low;
      logic low_supply;
      logic high_supply;
      logic surge;
      logic hot;
      logic overcurrent;
   } rcs_flags_t;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_DETECT = 4'h2,
      ST_HOLD = 4'h4,
      ST_RELEASE = 4'h8
   } rcs_state_t;
endpackage

/* hdl/rcs_top.sv */
`timescale 1ns/10ps
`include "rcs_defs.svh"
// Operation
// - Each of system, disc, audio, lamp rails follows its own enable bit.
// - Voltage selection field changes only while its rail enable is 0.
// - Read word returns current voltage selections.
// - Battery switch output follows its own enable bit.
// - Over-current flag set when any switched output is over-current.
// - While reset output low, control logic reset and registers initialised.
// - Logic rail above release level frees reset; internal reset ends later.
// - Main supply below chosen threshold sets low flag, battery alarm low.
// - Main supply above high level sets high flag, battery alarm low.
// - Ignition below chosen level sets ignition flag, ignition alarm low.
// - Supply, ignition and warning detections never change rail states.
// - Surge on either supply sets surge flag, turns off all but logic rail.
// - Surge clears power enables; no automatic re-enable after release.
// - Battery alarm low for whole surge condition.
// - Thermal shutdown turns all off; recovery restores logic rail, bus and the prior rail and switch enables.
// - Hot warning set above warning temperature, cleared below release.
// - Battery alarm on low/high supply; hot warning only with mode bit 1.
// - Low threshold field: 11 8V, 10/01 7.5V differing hysteresis, 00 6.5V.
// - Ignition field: 11 4.2V, 10 3.6V, 01 3.2V, 00 2.7V.
// - Alarm mode is bit 3 of monitor config register at 08h.
// - Flag byte: ignition 7, low 6, high 5, surge 4, hot 3, over-current 2.
module rcs_top
   import rcs_pkg::*;
#(
   parameter int ASSERT_CYC = (`RCS_ASSERT_DELAY_NS * `RCS_CLK_MHZ + `RCS_NS_PER_US - 1) / `RCS_NS_PER_US,
   parameter int RELEASE_CYC = (`RCS_RELEASE_DELAY_NS * `RCS_CLK_MHZ + `RCS_NS_PER_US - 1) / `RCS_NS_PER_US,
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   input wire logic [15:0] core_supply_mv_i,
   input wire logic [15:0] main_supply_mv_i,
   input wire logic [15:0] ignition_mv_i,
   input wire logic [7:0] die_temp_i,
   input wire logic [4:0] overcurrent_i,
   output logic [3:0] rail_enable_o,
   output logic [7:0] voltage_sel_o,
   output logic switch_enable_o,
   output logic logic_rail_on_o,
   output logic reset_out_n_o,
   output logic reset_out_n_oe_o,
   output logic battery_alarm_n_o,
   output logic battery_alarm_n_oe_o,
   output logic ignition_alarm_n_o,
   output logic ignition_alarm_n_oe_o
);
   localparam logic [CNT_W-1:0] ASSERT_LAST = CNT_W'(ASSERT_CYC - 1);
   localparam logic [CNT_W-1:0] RELEASE_LAST = CNT_W'(RELEASE_CYC - 1);

   rcs_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   rcs_flags_t flags_reg, flags_next;
   logic tsd_reg, tsd_next;
   logic [7:0] pwr_reg, pwr_next, vsel_reg, vsel_next, cfg_reg, cfg_next;
   logic [3:0] rail_reg, rail_next;
   logic sw_reg, sw_next, batt_reg, batt_next;
   logic [31:0] rdata_reg, rdata_next;
   logic err_reg, err_next;
   logic core_low, core_high, soft_rst, setup, access, unmapped;
   logic wr_pwr, wr_vsel, wr_cfg;
   logic [1:0] idx;
   logic [7:0] lock, flag_byte;
   logic [15:0] low_th, low_rel, ign_th;

   // ****************************************
   // Reset supervisor
   // ****************************************
   assign core_low = core_supply_mv_i < `RCS_CORE_LOW;
   assign core_high = core_supply_mv_i > `RCS_CORE_REL;
   assign soft_rst = state_reg == ST_HOLD || state_reg == ST_RELEASE;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         ST_RUN: begin
            if (core_low) begin
               state_next = ST_DETECT;
               cnt_next = '0;
            end
         end
         ST_DETECT: begin
            if (!core_low) begin
               state_next = ST_RUN;
            end else if (cnt_reg == ASSERT_LAST) begin
               state_next = ST_HOLD;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_HOLD: begin
            if (core_high) begin
               state_next = ST_RELEASE;
               cnt_next = '0;
            end
         end
         ST_RELEASE: begin
            if (core_low) begin
               state_next = ST_HOLD;
            end else if (cnt_reg == RELEASE_LAST) begin
               state_next = ST_RUN;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
      endcase
   end

   // Power-up behaves like a supervisor reset, so registers start clean
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_HOLD;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************
   // Supply, ignition and die monitors
   // ****************************************
   always_comb begin
      unique case (cfg_reg[`RCS_CFG_LOW])
         2'b11: begin
            low_th = `RCS_LOW_8V0;
            low_rel = `RCS_LOW_8V5;
         end
         2'b10: begin
            low_th = `RCS_LOW_7V5;
            low_rel = `RCS_LOW_9V0;
         end
         2'b01: begin
            low_th = `RCS_LOW_7V5;
            low_rel = `RCS_LOW_8V0;
         end
         2'b00: begin
            low_th = `RCS_LOW_6V5;
            low_rel = `RCS_LOW_7V0;
         end
      endcase
      unique case (cfg_reg[`RCS_CFG_IGN])
         2'b11: ign_th = `RCS_IGN_4V2;
         2'b10: ign_th = `RCS_IGN_3V6;
         2'b01: ign_th = `RCS_IGN_3V2;
         2'b00: ign_th = `RCS_IGN_2V7;
      endcase
   end

   // Hysteresis: a set low, surge or hot flag, or shutdown, holds until the input passes its release level
   always_comb begin
      flags_next.low_supply = flags_reg.low_supply ? main_supply_mv_i < low_rel
                              : main_supply_mv_i < low_th;
      flags_next.high_supply = main_supply_mv_i > `RCS_HIGH_LVL;
      flags_next.ign_low = ignition_mv_i < ign_th;
      flags_next.surge = flags_reg.surge ?
                         (core_supply_mv_i >= `RCS_SURGE_REL || main_supply_mv_i >= `RCS_SURGE_REL) :
                         (core_supply_mv_i > `RCS_SURGE_LVL || main_supply_mv_i > `RCS_SURGE_LVL);
      flags_next.hot = flags_reg.hot ? die_temp_i >= `RCS_HOT_REL : die_temp_i > `RCS_HOT_LVL;
      flags_next.overcurrent = |overcurrent_i;
      tsd_next = tsd_reg ? die_temp_i >= `RCS_TSD_REL : die_temp_i > `RCS_TSD_LVL;
   end

   // Monitors keep running through supervisor reset, as in standby
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags_reg <= '0;
         tsd_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         tsd_reg <= tsd_next;
      end
   end

   // ****************************************
   // Registers and outputs
   // ****************************************
   assign idx = paddr_i[3:2];
   assign setup = psel_i && !penable_i;
   assign access = psel_i && penable_i;
   assign unmapped = paddr_i[11:4] != '0 || paddr_i[1:0] != '0;
   // No bus control while the die is in thermal shutdown
   assign wr_pwr = access && pwrite_i && !unmapped && !tsd_reg && idx == `RCS_IDX_PWR;
   assign wr_vsel = access && pwrite_i && !unmapped && !tsd_reg && idx == `RCS_IDX_VSEL;
   assign wr_cfg = access && pwrite_i && !unmapped && !tsd_reg && idx == `RCS_IDX_CFG;
   assign lock = {{2{pwr_reg[`RCS_PWR_LAMP]}}, {2{pwr_reg[`RCS_PWR_DISC]}},
                  {2{pwr_reg[`RCS_PWR_AUDIO]}}, pwr_reg[`RCS_PWR_SYS], 1'b1};

   always_comb begin
      pwr_next = pwr_reg;
      vsel_next = vsel_reg;
      cfg_next = cfg_reg;
      if (soft_rst) begin
         pwr_next = `RCS_RST_VAL;
         vsel_next = `RCS_RST_VAL;
         cfg_next = `RCS_RST_VAL;
      end else begin
         if (wr_pwr) begin
            pwr_next = pwdata_i[7:0] & `RCS_PWR_MASK;
         end
         if (wr_vsel) begin
            vsel_next = (vsel_reg & lock) | (pwdata_i[7:0] & ~lock & `RCS_VSEL_MASK);
         end
         if (wr_cfg) begin
            cfg_next = pwdata_i[7:0] & `RCS_CFG_MASK;
         end
         // Surge wins over a same-cycle write and keeps enables cleared
         if (flags_reg.surge) begin
            pwr_next = `RCS_RST_VAL;
         end
      end
      // Only surge and shutdown gate the rails; other detections leave them alone
      rail_next = (flags_next.surge || tsd_next) ? 4'h0 : pwr_next[`RCS_PWR_RAILS];
      sw_next = pwr_next[`RCS_PWR_SW] && !flags_next.surge && !tsd_next;
      batt_next = flags_next.low_supply || flags_next.high_supply || flags_next.surge
                  || (flags_next.hot && cfg_next[`RCS_CFG_MODE]);
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwr_reg <= `RCS_RST_VAL;
         vsel_reg <= `RCS_RST_VAL;
         cfg_reg <= `RCS_RST_VAL;
         rail_reg <= 4'h0;
         sw_reg <= 1'b0;
         batt_reg <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         vsel_reg <= vsel_next;
         cfg_reg <= cfg_next;
         rail_reg <= rail_next;
         sw_reg <= sw_next;
         batt_reg <= batt_next;
      end
   end

   assign rail_enable_o = rail_reg;
   assign voltage_sel_o = vsel_reg;
   assign switch_enable_o = sw_reg;
   assign logic_rail_on_o = !tsd_reg;
   assign reset_out_n_o = 1'b0;
   assign reset_out_n_oe_o = state_reg == ST_HOLD;
   assign battery_alarm_n_o = 1'b0;
   assign battery_alarm_n_oe_o = batt_reg;
   assign ignition_alarm_n_o = 1'b0;
   assign ignition_alarm_n_oe_o = flags_reg.ign_low;

   // ****************************************
   // Read path
   // ****************************************
   assign flag_byte = {flags_reg.ign_low, flags_reg.low_supply, flags_reg.high_supply,
                       flags_reg.surge, flags_reg.hot, flags_reg.overcurrent, 2'b00};

   // Read data is captured in the setup cycle, so a flag edge mid-access cannot tear the word
   always_comb begin
      rdata_next = rdata_reg;
      err_next = err_reg;
      if (setup) begin
         err_next = unmapped || (pwrite_i && idx == `RCS_IDX_FLT);
         unique case (idx)
            `RCS_IDX_PWR: rdata_next = {24'h00_0000, pwr_reg};
            `RCS_IDX_VSEL: rdata_next = {24'h00_0000, vsel_reg};
            `RCS_IDX_CFG: rdata_next = {24'h00_0000, cfg_reg};
            `RCS_IDX_FLT: rdata_next = {16'h0000, vsel_reg, flag_byte};
         endcase
         if (unmapped || pwrite_i) begin
            rdata_next = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   assign pready_o = access;
   assign prdata_o = rdata_reg;
   assign pslverr_o = access && err_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_fault_setup;
      setup && !pwrite_i && !unmapped && idx == `RCS_IDX_FLT;
   endsequence

   property p_rail_follow;
      wr_pwr && !soft_rst && !flags_reg.surge && !flags_next.surge && !tsd_next
      |=> rail_enable_o == $past(pwdata_i[7:4]);
   endproperty
   a_rail_follow: assert property (p_rail_follow) else $error("rail enables do not follow write");

   property p_vsel_lock;
      pwr_reg[`RCS_PWR_LAMP] && !soft_rst |=> vsel_reg[7:6] == $past(vsel_reg[7:6]);
   endproperty
   a_vsel_lock: assert property (p_vsel_lock) else $error("selection changed while rail enabled");

   property p_readback;
      s_fault_setup |=> prdata_o[15:0] == {$past(vsel_reg), $past(flag_byte)};
   endproperty
   a_readback: assert property (p_readback) else $error("fault word readback wrong");

   property p_snapshot;
      s_fault_setup ##1 access |=> $stable(prdata_o);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("read data moved during access");

   property p_overcurrent;
      (|overcurrent_i) |=> flags_reg.overcurrent;
   endproperty
   a_overcurrent: assert property (p_overcurrent) else $error("over-current flag missing");

   property p_assert_delay;
      state_reg == ST_DETECT && cnt_reg == ASSERT_LAST && core_low |=> reset_out_n_oe_o;
   endproperty
   a_assert_delay: assert property (p_assert_delay) else $error("reset output not asserted");

   property p_regs_clear;
      reset_out_n_oe_o |=> pwr_reg == `RCS_RST_VAL && vsel_reg == `RCS_RST_VAL && cfg_reg == `RCS_RST_VAL;
   endproperty
   a_regs_clear: assert property (p_regs_clear) else $error("registers not cleared in reset");

   property p_release;
      reset_out_n_oe_o && core_high |=> !reset_out_n_oe_o && soft_rst;
   endproperty
   a_release: assert property (p_release) else $error("reset release sequence wrong");

   property p_high_alarm;
      main_supply_mv_i > `RCS_HIGH_LVL |=> flags_reg.high_supply && battery_alarm_n_oe_o;
   endproperty
   a_high_alarm: assert property (p_high_alarm) else $error("high supply alarm missing");

   property p_surge_off;
      flags_reg.surge |-> rail_enable_o == 4'h0 && !switch_enable_o && battery_alarm_n_oe_o;
   endproperty
   a_surge_off: assert property (p_surge_off) else $error("outputs alive during surge");

   property p_surge_pm;
      flags_reg.surge |=> pwr_reg == `RCS_RST_VAL;
   endproperty
   a_surge_pm: assert property (p_surge_pm) else $error("enables not cleared by surge");

   property p_hot_mode;
      flags_reg.hot && !flags_reg.low_supply && !flags_reg.high_supply && !flags_reg.surge
      && !cfg_reg[`RCS_CFG_MODE] |-> !battery_alarm_n_oe_o;
   endproperty
   a_hot_mode: assert property (p_hot_mode) else $error("hot warning alarm in mode 0");
endmodule

/* verif/rcs_host.sv */
`timescale 1ns/10ps
// ****************************************
// Host bus controller model
// ****************************************
module rcs_host (
   input wire logic clk_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [11:0] paddr_o,
   output logic [31:0] pwdata_o,
   input wire logic pready_i,
   input wire logic [31:0] prdata_i,
   input wire logic pslverr_i
);
   logic hung = 1'b0;
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 12'hFFF;
      pwdata_o = 32'h0000_0000;
   end
   // One transfer; the task drives selection one cycle before enable
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 16);
      if (pready_i !== 1'b1) hung = 1'b1;
      r = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Released lines must not keep showing the last value
      paddr_o <= ~a;
      pwdata_o <= ~d;
   endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/10ps
`include "rcs_defs.svh"
module tb_top;
   localparam int AC = 4;
   localparam int RC = 8;
   localparam logic [11:0] A_PWR = {8'h00, `RCS_IDX_PWR, 2'b00};
   localparam logic [11:0] A_VS = {8'h00, `RCS_IDX_VSEL, 2'b00};
   localparam logic [11:0] A_CFG = {8'h00, `RCS_IDX_CFG, 2'b00};
   localparam logic [11:0] A_FLT = {8'h00, `RCS_IDX_FLT, 2'b00};
   localparam logic [15:0] NC = 16'h0CE4;
   localparam logic [15:0] NM = 16'h2EE0;
   localparam logic [15:0] NI = 16'h1388;
   localparam logic [7:0] NT = 8'h19;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] core_mv = NC;
   logic [15:0] main_mv = NM;
   logic [15:0] ign_mv = NI;
   logic [7:0] temp = NT;
   logic [4:0] oc = 5'h00;
   logic [3:0] rails;
   logic [7:0] vsel;
   logic sw, lrail, rst_v, rst_oe, bat_v, bat_oe, ign_v, ign_oe;
   logic [15:0] lowt [4] = '{`RCS_LOW_6V5, `RCS_LOW_7V5, `RCS_LOW_7V5, `RCS_LOW_8V0};
   logic [15:0] ignt [4] = '{`RCS_IGN_2V7, `RCS_IGN_3V2, `RCS_IGN_3V6, `RCS_IGN_4V2};
   logic [11:0] bad [3] = '{12'h010, 12'h002, 12'h800};
   logic [31:0] r;
   logic e;
   int fails = 0;
   int n_compared = 0;
   always #2.5 clk_i = ~clk_i;
   rcs_top #(.ASSERT_CYC(AC), .RELEASE_CYC(RC)) uut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
      .core_supply_mv_i(core_mv), .main_supply_mv_i(main_mv), .ignition_mv_i(ign_mv),
      .die_temp_i(temp), .overcurrent_i(oc), .rail_enable_o(rails), .voltage_sel_o(vsel),
      .switch_enable_o(sw), .logic_rail_on_o(lrail), .reset_out_n_o(rst_v), .reset_out_n_oe_o(rst_oe),
      .battery_alarm_n_o(bat_v), .battery_alarm_n_oe_o(bat_oe), .ignition_alarm_n_o(ign_v),
      .ignition_alarm_n_oe_o(ign_oe));
   rcs_host hm (
      .clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
      .pwdata_o(pwdata), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr));
   // ****************************************
   // Checking and access tasks
   // ****************************************
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, x, g);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      hm.xfer(w, a, d, r, e);
      if (hm.hung) begin
         fails++;
         final_report();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0000_0000);
      chk("read data", x, r);
      chk("read error", 32'h0000_0000, {31'h0, e});
   endtask
   task automatic st(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Pins: rails, switch, logic rail, reset, battery alarm, ignition alarm
   task automatic out(input logic [8:0] x);
      chk("pins", {x, 1'b0}, {22'h0, rails, sw, lrail, rst_oe, bat_oe, ign_oe, rst_v | bat_v | ign_v});
   endtask
   task automatic env(input logic [15:0] c, m, g, input logic [7:0] t, input logic [4:0] o);
      @(posedge clk_i);
      core_mv <= c;
      main_mv <= m;
      ign_mv <= g;
      temp <= t;
      oc <= o;
      st(3);
   endtask
   task automatic wt(input logic v);
      for (int n = 0; n < 100 && rst_oe !== v; n++) @(posedge clk_i);
      if (rst_oe !== v) begin
         fails++;
         final_report();
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      wt(1'b0);
      st(RC + 2);
      out(9'h008);
      rd(A_PWR, 32'h0000_0000);
      rd(A_CFG, 32'h0000_0000);
      wr(A_VS, 32'h0000_00AA);
      rd(A_VS, 32'h0000_00AA);
      rd(A_FLT, 32'h0000_AA00);
      for (int i = 0; i < 5; i++) begin
         logic [7:0] d;
         d = 8'h08 << i;
         wr(A_PWR, {24'h0, d});
         st(1);
         out({d[7:3], 4'b1000});
      end
      wr(A_PWR, 32'h0000_00F8);
      wr(A_VS, 32'h0000_0054);
      st(1);
      chk("selection", 32'h0000_00AA, {24'h0, vsel});
      wr(A_PWR, 32'h0000_0078);
      wr(A_VS, 32'h0000_0054);
      rd(A_VS, 32'h0000_006A);
      for (int i = 0; i < 5; i++) begin
         env(NC, NM, NI, NT, 5'h01 << i);
         rd(A_FLT, 32'h0000_6A04);
      end
      env(NC, NM, NI, NT, 5'h00);
      for (int i = 0; i < 4; i++) begin
         wr(A_CFG, {24'h0, 2'b00, 2'(i), 4'h0});
         env(NC, lowt[i] - 16'h0001, NI, NT, 5'h00);
         rd(A_FLT, 32'h0000_6A40);
         out(9'h0FA);
         env(NC, lowt[i] + 16'h01F4, NI, NT, 5'h00);
         rd(A_FLT, {16'h0000, 8'h6A, 1'b0, i == 2, 6'h00});
         env(NC, NM, NI, NT, 5'h00);
      end
      for (int i = 0; i < 4; i++) begin
         wr(A_CFG, {24'h0, 2'(i), 6'h00});
         env(NC, NM, ignt[i], NT, 5'h00);
         rd(A_FLT, 32'h0000_6A00);
         env(NC, NM, ignt[i] - 16'h0001, NT, 5'h00);
         rd(A_FLT, 32'h0000_6A80);
         out(9'h0F9);
      end
      env(NC, `RCS_HIGH_LVL + 16'h0001, NI, NT, 5'h00);
      rd(A_FLT, 32'h0000_6A20);
      out(9'h0FA);
      env(NC, `RCS_HIGH_LVL, NI, NT, 5'h00);
      rd(A_FLT, 32'h0000_6A00);
      wr(A_CFG, 32'h0000_0000);
      env(NC, NM, NI, `RCS_HOT_LVL + 8'h01, 5'h00);
      rd(A_FLT, 32'h0000_6A08);
      out(9'h0F8);
      wr(A_CFG, 32'h0000_0008);
      st(1);
      out(9'h0FA);
      env(NC, NM, NI, `RCS_HOT_REL, 5'h00);
      rd(A_FLT, 32'h0000_6A08);
      env(NC, NM, NI, `RCS_HOT_REL - 8'h01, 5'h00);
      rd(A_FLT, 32'h0000_6A00);
      out(9'h0F8);
      env(NC, `RCS_SURGE_LVL + 16'h0001, NI, NT, 5'h00);
      rd(A_FLT, 32'h0000_6A30);
      out(9'h00A);
      wr(A_PWR, 32'h0000_00F8);
      rd(A_PWR, 32'h0000_0000);
      env(NC, `RCS_SURGE_REL, NI, NT, 5'h00);
      rd(A_FLT, 32'h0000_6A30);
      env(`RCS_SURGE_LVL + 16'h0001, NM, NI, NT, 5'h00);
      rd(A_FLT, 32'h0000_6A10);
      env(NC, NM, NI, NT, 5'h00);
      out(9'h008);
      wr(A_PWR, 32'h0000_00F8);
      env(NC, NM, NI, `RCS_TSD_LVL + 8'h01, 5'h00);
      out(9'h002);
      wr(A_PWR, 32'h0000_0000);
      env(NC, NM, NI, `RCS_TSD_REL, 5'h00);
      out(9'h002);
      env(NC, NM, NI, `RCS_TSD_REL - 8'h01, 5'h00);
      out(9'h1FA);
      env(`RCS_CORE_LOW - 16'h0001, NM, NI, NT, 5'h00);
      chk("reset early", 32'h0000_0000, {31'h0, rst_oe});
      wt(1'b1);
      st(1);
      out(9'h00C);
      @(posedge clk_i);
      core_mv <= NC;
      wt(1'b0);
      wr(A_PWR, 32'h0000_00F8);
      st(RC + 2);
      rd(A_PWR, 32'h0000_0000);
      rd(A_VS, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         acc(1'b0, bad[i], 32'h0000_0000);
         chk("bad error", 32'h0000_0001, {31'h0, e});
         chk("bad data", 32'h0000_0000, r);
      end
      acc(1'b1, A_FLT, 32'h0000_00FF);
      chk("ro error", 32'h0000_0001, {31'h0, e});
      final_report();
   end
endmodule
